// ---- src/cfdr_top.sv ----
/*
 * Clock fail detect and recovery: APB registers, system clock failure
 * detection with switch-over to the watchdog oscillator, watchdog
 * oscillator failure detection, trap events and interrupt.
 * Assumes sys_clk_in is the always-running reference for this logic; the
 * monitored clocks arrive as levels synchronous to it; the host stops both
 * detectors before changing the clock source.
 */
module cfdr_top #(
    parameter int WD_LIMIT = cfdr_pkg::CFDR_WDFAIL_CYCLES,
    parameter int SYS_LIMIT = int'(cfdr_pkg::CFDR_SYSFAIL_CYCLES)
) (
    input wire logic sys_clk_in, // 200 MHz block clock
    input wire logic rst_in, // Synchronous reset, active high
    input wire logic psel_in, // APB select
    input wire logic penable_in, // APB enable
    input wire logic pwrite_in, // APB direction
    input wire logic [11:0] paddr_in, // APB byte address
    input wire logic [31:0] pwdata_in, // APB write data
    output logic [31:0] prdata_out, // APB read data
    output logic pready_out, // APB ready
    output logic pslverr_out, // APB error, unmapped address
    input wire logic primary_clk_lvl_in, // Primary oscillator level
    input wire logic wdog_clk_lvl_in, // Watchdog oscillator level
    output logic [1:0] clock_source_select_out, // Effective clock source
    output logic internal_precision_osc_en_out, // Precision oscillator enable
    output logic wdog_osc_en_out, // Watchdog oscillator enable
    output logic sys_fail_trap_out, // Primary failure trap pulse
    output logic wdog_fail_trap_out, // Watchdog failure trap pulse
    output logic irq_out // Level interrupt
);
    initial begin
        if (WD_LIMIT < 2 || WD_LIMIT > 65535 || SYS_LIMIT < 2 || SYS_LIMIT >= (1 << 24)) begin
            $error("cfdr_top: limit out of range");
        end
    end

    // Register state
    cfdr_pkg::cfdr_ctrl_t ctrl, next_ctrl;
    cfdr_pkg::cfdr_evt_t status, next_status;
    cfdr_pkg::cfdr_evt_t mask, next_mask;
    logic wd_failed, next_wd_failed;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic next_irq;
    logic next_sys_trap;
    logic next_wd_trap;
    logic [1:0] next_src_out;

    // Primary oscillator gap counter
    logic [23:0] sys_count, next_sys_count;
    logic sys_last, next_sys_last;
    logic sys_expire;

    logic wd_expire;
    logic wd_detect_on;
    logic sys_detect_on;
    logic acc;
    logic wr;

    function automatic logic mapped(input logic [11:0] a);
        return a == cfdr_pkg::CFDR_OFF_OSC_CTRL || a == cfdr_pkg::CFDR_OFF_STATUS ||
            a == cfdr_pkg::CFDR_OFF_MASK || a == cfdr_pkg::CFDR_OFF_STATE;
    endfunction

    assign acc = psel_in && penable_in && !pready_out;
    assign wr = acc && pwrite_in && mapped(paddr_in);
    // Watchdog osc off or selected: detection impossible, forced off too.
    assign wd_detect_on = ctrl.wdfd_en && ctrl.wdosc_en &&
        (ctrl.src != cfdr_pkg::CFDR_SRC_WDOG);
    assign sys_detect_on = ctrl.sysfd_en && !wd_failed;

    cfdr_gap_timer #(
        .LIMIT(WD_LIMIT),
        .CW(16)
    ) u_wd_gap (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .enable_in(wd_detect_on),
        .level_in(wdog_clk_lvl_in),
        .expired_out(wd_expire)
    );

    // Primary oscillator watch: no edge within 1 ms means below ~500 Hz
    always_comb begin
        next_sys_last = primary_clk_lvl_in;
        next_sys_count = sys_count;
        sys_expire = 1'b0;
        if (!sys_detect_on || primary_clk_lvl_in != sys_last) begin
            next_sys_count = '0;
        end else if (sys_count == 24'(SYS_LIMIT - 1)) begin
            next_sys_count = '0;
            sys_expire = 1'b1;
        end else begin
            next_sys_count = sys_count + 1'b1;
        end
    end

    // Register file and event logic
    always_comb begin
        next_ctrl = ctrl;
        next_status = status;
        next_mask = mask;
        next_wd_failed = wd_failed;
        next_sys_trap = 1'b0;
        next_wd_trap = 1'b0;
        next_prdata = 32'h0000_0000;
        next_pready = acc;
        next_pslverr = acc && !mapped(paddr_in);
        if (wr) begin
            unique case (paddr_in)
                cfdr_pkg::CFDR_OFF_OSC_CTRL: begin
                    // Any field may change in the same write; no lockout
                    next_ctrl = cfdr_pkg::cfdr_ctrl_t'({pwdata_in[cfdr_pkg::CFDR_CTL_WDOSC_BIT],
                        pwdata_in[cfdr_pkg::CFDR_CTL_IPO_BIT],
                        pwdata_in[cfdr_pkg::CFDR_CTL_WDFD_BIT],
                        pwdata_in[cfdr_pkg::CFDR_CTL_SYSFD_BIT],
                        pwdata_in[cfdr_pkg::CFDR_CTL_SRC_LSB +: cfdr_pkg::CFDR_CTL_SRC_W]});
                end
                cfdr_pkg::CFDR_OFF_STATUS: begin
                    next_status = status & ~cfdr_pkg::cfdr_evt_t'(pwdata_in[1:0]);
                end
                cfdr_pkg::CFDR_OFF_MASK: begin
                    next_mask = cfdr_pkg::cfdr_evt_t'(pwdata_in[1:0]);
                end
                default: begin
                end
            endcase
        end
        if (acc && !pwrite_in) begin
            unique case (paddr_in)
                cfdr_pkg::CFDR_OFF_OSC_CTRL: next_prdata = {24'h000000, ctrl.wdosc_en,
                    ctrl.ipo_en, ctrl.wdfd_en, ctrl.sysfd_en, 2'h0, ctrl.src};
                cfdr_pkg::CFDR_OFF_STATUS: next_prdata = {30'h0, status};
                cfdr_pkg::CFDR_OFF_MASK: next_prdata = {30'h0, mask};
                cfdr_pkg::CFDR_OFF_STATE: next_prdata = {29'h0, wd_failed, clock_source_select_out};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        // Primary failure: trap, and recover onto the watchdog oscillator only if wdosc_en is set
        if (sys_expire) begin
            next_sys_trap = 1'b1;
            next_status.sys_fail = 1'b1;
            if (ctrl.wdosc_en) begin
                next_ctrl.src = cfdr_pkg::CFDR_SRC_WDOG;
            end
        end
        // Watchdog failure: alert and block primary detection, source untouched
        if (wd_expire) begin
            next_wd_trap = 1'b1;
            next_status.wd_fail = 1'b1;
            next_wd_failed = 1'b1;
        end
        next_src_out = next_ctrl.src;
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ctrl <= '{wdosc_en: cfdr_pkg::CFDR_RST_WDOSC_EN, ipo_en: cfdr_pkg::CFDR_RST_IPO_EN,
                wdfd_en: 1'b0, sysfd_en: 1'b0, src: cfdr_pkg::CFDR_RST_SRC};
            status <= '0;
            mask <= cfdr_pkg::CFDR_RST_MASK;
            wd_failed <= 1'b0;
            sys_count <= '0;
            sys_last <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            irq_out <= 1'b0;
            sys_fail_trap_out <= 1'b0;
            wdog_fail_trap_out <= 1'b0;
            clock_source_select_out <= cfdr_pkg::CFDR_RST_SRC;
            internal_precision_osc_en_out <= cfdr_pkg::CFDR_RST_IPO_EN;
            wdog_osc_en_out <= cfdr_pkg::CFDR_RST_WDOSC_EN;
        end else begin
            ctrl <= next_ctrl;
            status <= next_status;
            mask <= next_mask;
            wd_failed <= next_wd_failed;
            sys_count <= next_sys_count;
            sys_last <= next_sys_last;
            prdata_out <= next_prdata;
            pready_out <= next_pready;
            pslverr_out <= next_pslverr;
            irq_out <= next_irq;
            sys_fail_trap_out <= next_sys_trap;
            wdog_fail_trap_out <= next_wd_trap;
            clock_source_select_out <= next_src_out;
            internal_precision_osc_en_out <= next_ctrl.ipo_en;
            wdog_osc_en_out <= next_ctrl.wdosc_en;
        end
    end

    sequence sys_fail_seq;
        sys_expire && ctrl.wdosc_en;
    endsequence

    switch_over_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        sys_fail_seq |=> clock_source_select_out == cfdr_pkg::CFDR_SRC_WDOG && sys_fail_trap_out)
        else $error("no switch-over after primary failure");
    no_switch_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        sys_expire && !ctrl.wdosc_en && !wr |=> $stable(clock_source_select_out))
        else $error("switch-over with watchdog osc off");
    sys_trap_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        sys_expire |=> sys_fail_trap_out && status.sys_fail)
        else $error("primary failure trap missing");
    wd_trap_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wd_expire && !sys_expire && !wr |=> wdog_fail_trap_out && $stable(ctrl.src))
        else $error("watchdog alert wrong");
    wd_blocks_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wd_failed |-> !sys_expire) else $error("primary detect after wd fail");
    ipo_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !wr |=> ctrl.ipo_en == $past(ctrl.ipo_en)) else $error("ipo changed alone");
    sys_bound_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        sys_expire |-> sys_count == 24'(SYS_LIMIT - 1)) else $error("primary limit off");
    reenable_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr && paddr_in == cfdr_pkg::CFDR_OFF_OSC_CTRL |=> ctrl.sysfd_en == $past(pwdata_in[4]))
        else $error("detector enable write lost");
    irq_level_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ##1 irq_out == |($past(next_status) & $past(next_mask)))
        else $error("irq mismatch");
endmodule // cfdr_top

// ---- src/cfdr_pkg.sv ----
/*
 * Package for the clock fail detect and recovery block: APB register map,
 * field positions, reset values, timing counts and carrier structs.
 * Assumes a 200 MHz system clock and 32-bit APB with word-aligned registers.
 */
package cfdr_pkg;

    // Register byte offsets
    localparam logic [11:0] CFDR_OFF_OSC_CTRL = 12'h000;
    localparam logic [11:0] CFDR_OFF_STATUS = 12'h004;
    localparam logic [11:0] CFDR_OFF_MASK = 12'h008;
    localparam logic [11:0] CFDR_OFF_STATE = 12'h00c;

    // Oscillator control fields
    localparam int CFDR_CTL_SRC_LSB = 0;
    localparam int CFDR_CTL_SRC_W = 2;
    localparam int CFDR_CTL_SYSFD_BIT = 4;
    localparam int CFDR_CTL_WDFD_BIT = 5;
    localparam int CFDR_CTL_IPO_BIT = 6;
    localparam int CFDR_CTL_WDOSC_BIT = 7;

    // Status and mask fields (same layout)
    localparam int CFDR_ST_SYSFAIL_BIT = 0;
    localparam int CFDR_ST_WDFAIL_BIT = 1;
    localparam int CFDR_ST_W = 2;

    // Clock source encodings
    localparam logic [1:0] CFDR_SRC_IPO = 2'h0;
    localparam logic [1:0] CFDR_SRC_XTAL = 2'h1;
    localparam logic [1:0] CFDR_SRC_EXT = 2'h2;
    localparam logic [1:0] CFDR_SRC_WDOG = 2'h3;

    // Reset values
    localparam logic [1:0] CFDR_RST_SRC = CFDR_SRC_IPO;
    localparam logic CFDR_RST_IPO_EN = 1'b1;
    localparam logic CFDR_RST_WDOSC_EN = 1'b1;
    localparam logic [1:0] CFDR_RST_MASK = 2'h0;

    // Timing
    localparam int CFDR_SYSCLK_MHZ = 200;
    localparam int CFDR_SYSFAIL_HZ = 1000;
    localparam int CFDR_WDFAIL_CYCLES = 8004;
    localparam longint CFDR_SYSFAIL_CYCLES =
        (longint'(CFDR_SYSCLK_MHZ) * 1000000) / CFDR_SYSFAIL_HZ;

    typedef struct packed {
        logic wdosc_en;
        logic ipo_en;
        logic wdfd_en;
        logic sysfd_en;
        logic [1:0] src;
    } cfdr_ctrl_t;

    typedef struct packed {
        logic wd_fail;
        logic sys_fail;
    } cfdr_evt_t;

endpackage : cfdr_pkg

// ---- src/cfdr_gap_timer.sv ----
/*
 * Edge gap timer: counts reference cycles between edges of a monitored
 * level and pulses when the gap reaches a limit.
 * Assumes the monitored level is already synchronous to sys_clk_in.
 */
module cfdr_gap_timer #(
    parameter int LIMIT = 8004,
    parameter int CW = 16
) (
    input wire logic sys_clk_in, // System clock
    input wire logic rst_in, // Synchronous reset
    input wire logic enable_in, // Counting allowed
    input wire logic level_in, // Monitored level
    output logic expired_out // One-cycle pulse at limit
);
    initial begin
        if (LIMIT < 2 || LIMIT >= (1 << CW)) begin
            $error("cfdr_gap_timer: LIMIT does not fit CW");
        end
    end

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic last_level;
    logic next_last_level;
    logic next_expired;

    always_comb begin
        next_last_level = level_in;
        next_count = count;
        next_expired = 1'b0;
        if (!enable_in || (level_in != last_level)) begin
            next_count = '0;
        end else if (count == CW'(LIMIT - 1)) begin
            next_count = '0;
            next_expired = 1'b1;
        end else begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            count <= '0;
            last_level <= 1'b0;
            expired_out <= 1'b0;
        end else begin
            count <= next_count;
            last_level <= next_last_level;
            expired_out <= next_expired;
        end
    end

    gap_cleared_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !enable_in |=> count == '0) else $error("gap counter not cleared");
    gap_bound_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        expired_out |-> $past(count) == CW'(LIMIT - 1))
        else $error("gap expired at wrong count");
endmodule // cfdr_gap_timer

// ---- sim/cfdr_cpu_model.sv ----
/*
 * CPU-side model that takes the two oscillator failure trap events.
 * Assumes trap pulses are registered on sys_clk_in; counts are cleared by reset.
 */
module cfdr_cpu_model (
    input wire logic sys_clk_in, // Block clock
    input wire logic rst_in, // Synchronous reset
    input wire logic sys_fail_trap_in, // Primary failure trap
    input wire logic wdog_fail_trap_in, // Watchdog failure trap
    output int sys_traps_out, // Primary traps taken
    output int wd_traps_out // Watchdog traps taken
);
    timeunit 1ns;
    timeprecision 1ps;
    // Counting edges high shows whether a trap stood longer than one cycle
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sys_traps_out <= 0;
            wd_traps_out <= 0;
        end else begin
            if (sys_fail_trap_in === 1'b1)
                sys_traps_out <= sys_traps_out + 1;
            if (wdog_fail_trap_in === 1'b1)
                wd_traps_out <= wd_traps_out + 1;
        end
    end
endmodule // cfdr_cpu_model

// ---- sim/cfdr_top_tb.sv ----
/*
 * Testbench for the clock fail detect block: APB master tasks and sequences.
 * Assumes shortened SYS_LIMIT and WD_LIMIT; oscillator levels made here.
 */
module cfdr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SYS_LIM = 50;
    localparam int WD_LIM = 20;
    localparam logic [11:0] CTL = cfdr_pkg::CFDR_OFF_OSC_CTRL;
    localparam logic [11:0] STS = cfdr_pkg::CFDR_OFF_STATUS;
    localparam logic [11:0] MSK = cfdr_pkg::CFDR_OFF_MASK;
    localparam logic [11:0] STA = cfdr_pkg::CFDR_OFF_STATE;
    logic sys_clk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, ipo_en, wdosc_en, sys_trap, wd_trap, irq;
    logic prim_lvl = 1'b0, wd_lvl = 1'b0, prim_run = 1'b1, wd_run = 1'b0;
    logic [2:0] wd_div = 3'h0;
    logic [1:0] src;
    int sys_traps, wd_traps, n;
    int miscompares = 0;
    int checks_done = 0;

    cfdr_top #(.WD_LIMIT(WD_LIM), .SYS_LIMIT(SYS_LIM)) DUT (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .primary_clk_lvl_in(prim_lvl), .wdog_clk_lvl_in(wd_lvl),
        .clock_source_select_out(src), .internal_precision_osc_en_out(ipo_en),
        .wdog_osc_en_out(wdosc_en), .sys_fail_trap_out(sys_trap),
        .wdog_fail_trap_out(wd_trap), .irq_out(irq));
    cfdr_cpu_model cpu (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .sys_fail_trap_in(sys_trap),
        .wdog_fail_trap_in(wd_trap), .sys_traps_out(sys_traps), .wd_traps_out(wd_traps));

    initial begin
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    // Watchdog edge every 8 cycles, well inside the shortened limit
    always @(posedge sys_clk_in) begin
        if (prim_run)
            prim_lvl <= ~prim_lvl;
        if (wd_run)
            wd_div <= wd_div + 3'h1;
        if (wd_run && wd_div == 3'h7)
            wd_lvl <= ~wd_lvl;
    end

    task automatic tally_and_finish();
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_rng(input string nm, input int lo, input int hi, input int g);
        checks_done++;
        if (g < lo || g > hi) begin
            miscompares++;
            $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge sys_clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (pready !== 1'b1) begin
            miscompares++;
            $display("wrong value pready expected 1 seen %b", pready);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        check(nm, e, rd);
    endtask
    task automatic wait_trap(input logic wd, output int c);
        c = 0;
        while ((wd ? wd_trap : sys_trap) !== 1'b1 && c < 1000) begin
            @(posedge sys_clk_in);
            c++;
        end
    endtask
    task automatic do_reset();
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        prim_run <= 1'b1;
        wd_run <= 1'b0;
        repeat (10) @(posedge sys_clk_in);
        rst_in <= 1'b0;
    endtask

    initial begin
        #50000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        do_reset();
        check("source", 32'h0, src);
        check("ipo_en", 32'h1, ipo_en);
        rdchk(CTL, 32'h000000c0, "ctrl");
        rdchk(STS, 32'h0, "status");
        rdchk(MSK, 32'h0, "mask");
        apb(1'b0, 12'h010, 32'h0);
        check("slverr", 32'h1, err);
        check("unmapped", 32'h0, rd);
        apb(1'b1, CTL, 32'h000000c1);
        check("ipo_kept", 32'h1, ipo_en);
        apb(1'b1, CTL, 32'h000000d1);
        rdchk(CTL, 32'h000000d1, "ctrl_reen");
        apb(1'b1, MSK, 32'h3);
        repeat (3 * SYS_LIM) @(posedge sys_clk_in);
        check("no_sys_trap", 32'h0, sys_traps);
        prim_run <= 1'b0;
        wait_trap(1'b0, n);
        check_rng("sys_gap", SYS_LIM / 2, SYS_LIM * 3 / 2, n);
        repeat (2) @(posedge sys_clk_in);
        check("sys_traps", 32'h1, sys_traps);
        check("switched", 32'h3, src);
        check("irq_sys", 32'h1, irq);
        rdchk(STA, 32'h3, "state_sw");
        // Detector off first, a stopped primary would set status again
        apb(1'b1, CTL, 32'h000000c1);
        apb(1'b1, STS, 32'h1);
        check("irq_clr", 32'h0, irq);
        apb(1'b1, CTL, 32'h00000080);
        check("ipo_off", 32'h0, ipo_en);
        do_reset();
        apb(1'b1, CTL, 32'h00000041);
        apb(1'b1, CTL, 32'h00000051);
        check("wdosc_off", 32'h0, wdosc_en);
        prim_run <= 1'b0;
        wait_trap(1'b0, n);
        check_rng("sys_gap2", SYS_LIM / 2, SYS_LIM * 3 / 2, n);
        repeat (2) @(posedge sys_clk_in);
        check("no_switch", 32'h1, src);
        do_reset();
        apb(1'b1, CTL, 32'h000000c1);
        repeat (3 * WD_LIM) @(posedge sys_clk_in);
        apb(1'b1, CTL, 32'h000000e1);
        wd_run <= 1'b1;
        repeat (5 * WD_LIM) @(posedge sys_clk_in);
        check("no_wd_trap", 32'h0, wd_traps);
        wd_run <= 1'b0;
        wait_trap(1'b1, n);
        check_rng("wd_gap", WD_LIM - 8, WD_LIM + 4, n);
        repeat (2) @(posedge sys_clk_in);
        check("wd_traps", 32'h1, wd_traps);
        check("wd_no_switch", 32'h1, src);
        check("irq_masked", 32'h0, irq);
        rdchk(STS, 32'h2, "status_wd");
        rdchk(STA, 32'h5, "state_wd");
        apb(1'b1, MSK, 32'h2);
        check("irq_wd", 32'h1, irq);
        apb(1'b1, CTL, 32'h000000c1);
        apb(1'b1, STS, 32'h2);
        check("irq_wd_clr", 32'h0, irq);
        apb(1'b1, CTL, 32'h000000d1);
        prim_run <= 1'b0;
        repeat (3 * SYS_LIM) @(posedge sys_clk_in);
        check("no_sys_after_wd", 32'h0, sys_traps);
        check("src_after_wd", 32'h1, src);
        tally_and_finish();
    end
endmodule // cfdr_top_tb
